// ==== shared/rscd_pkg.sv ====
// Constants, types and the clock-mode decode shared by the reset strap block.
// Assumes one 20 MHz system clock and strap inputs synchronous to it.
package rscd_pkg;

	// ----------------------------------------------------------------
	// Register map and fields
	// ----------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam logic [7:0] IDX_CLK_STRAP = 8'he2;
	localparam logic [7:0] IDX_STRAP_CTRL = 8'he3;
	localparam logic [7:0] IDX_STRAP_STAT = 8'he4;
	localparam int CODE_HI_LSB = 4;
	localparam int CODE_LO_BIT = 3;
	localparam int CTRL_DBG_EN_BIT = 0;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam int STAT_CAPTURED_BIT = 0;
	localparam int STAT_RESERVED_BIT = 1;
	localparam int STAT_BUS32_BIT = 2;
	localparam int STAT_OFF_BIT = 3;
	localparam int STAT_SBYP_BIT = 4;
	localparam int STAT_DBYP_BIT = 5;

	// ----------------------------------------------------------------
	// Strap codes, multipliers and counts
	// ----------------------------------------------------------------
	localparam int CODE_W = 5;
	// All-ones: every undriven strap reads high
	localparam logic [4:0] STRAP_RESET = 5'h1f;
	localparam logic [4:0] CODE_OFF_A = 5'h1e;
	localparam logic [4:0] CODE_OFF_B = 5'h1f;
	localparam logic [4:0] CODE_SINGLE_BYP = 5'h1c;
	localparam logic [4:0] CODE_DUAL_BYP = 5'h1d;
	// Multipliers held as twice their value so 2.5 and 4.5 stay whole
	localparam logic [3:0] MUL_X2_1 = 4'h2;
	localparam logic [3:0] MUL_X2_2 = 4'h4;
	localparam logic [3:0] MUL_X2_2P5 = 4'h5;
	localparam logic [3:0] MUL_X2_3 = 4'h6;
	localparam logic [3:0] MUL_X2_4P5 = 4'h9;
	localparam int CAPTURE_DELAY_CYCLES = 4;
	localparam int HOLD_MIN_CYCLES = 25;
	localparam int CNT_W = 5;

	typedef enum logic [2:0] {
		CS_PLL = 3'h0,
		CS_SINGLE_BYP = 3'h1,
		CS_DUAL_BYP = 3'h2,
		CS_OFF = 3'h3,
		CS_RESERVED = 3'h4
	} rscd_clk_src_type;

	typedef struct packed {
		rscd_clk_src_type src;
		logic [3:0] memMultX2;
		logic [3:0] coreMultX2;
		logic memBypass;
		logic periphPllEn;
		logic corePllEn;
		logic coreFromHostRef;
		logic coreFromCoreRef;
		logic periphFromHostRef;
		logic clocksRun;
	} rscd_clk_mode_type;

	typedef struct packed {
		logic [31:0] lowDout;
		logic [31:0] highDout;
		logic lowOe;
		logic highOe;
		logic lowRxEn;
		logic highRxEn;
		logic [7:0] parityDout;
		logic [7:0] parityRxEn;
	} rscd_lane_ctl_type;

	function automatic rscd_clk_mode_type decodeCode(input logic [4:0] code);
		rscd_clk_mode_type m;
		m = '0;
		m.src = CS_PLL;
		m.periphPllEn = 1'b1;
		m.corePllEn = 1'b1;
		m.clocksRun = 1'b1;
		case (code)
			5'h00: begin m.memMultX2 = MUL_X2_3; m.coreMultX2 = MUL_X2_2P5; end
			5'h01: begin m.memMultX2 = MUL_X2_3; m.coreMultX2 = MUL_X2_3; end
			5'h02: begin m.memMultX2 = MUL_X2_1; m.coreMultX2 = MUL_X2_4P5; end
			5'h03: begin
				m.memMultX2 = MUL_X2_1;
				m.coreMultX2 = MUL_X2_2;
				m.memBypass = 1'b1;
				m.periphPllEn = 1'b0;
			end
			5'h04: begin m.memMultX2 = MUL_X2_2; m.coreMultX2 = MUL_X2_2; end
			CODE_SINGLE_BYP: begin
				m.src = CS_SINGLE_BYP;
				m.memMultX2 = MUL_X2_1;
				m.coreMultX2 = MUL_X2_1;
				m.periphPllEn = 1'b0;
				m.corePllEn = 1'b0;
				m.coreFromHostRef = 1'b1;
			end
			CODE_DUAL_BYP: begin
				m.src = CS_DUAL_BYP;
				m.memMultX2 = MUL_X2_1;
				m.coreMultX2 = MUL_X2_1;
				m.periphPllEn = 1'b0;
				m.corePllEn = 1'b0;
				m.periphFromHostRef = 1'b1;
				m.coreFromCoreRef = 1'b1;
			end
			CODE_OFF_A, CODE_OFF_B: begin
				m = '0;
				m.src = CS_OFF;
			end
			default: begin
				// Unknown code: keep everything stopped rather than guess
				m = '0;
				m.src = CS_RESERVED;
			end
		endcase
		return m;
	endfunction : decodeCode

endpackage : rscd_pkg

// ==== logic/rscd_mode_decode.sv ====
// Registered clock-mode decoder for the captured strap code.
// Assumes load is a one-cycle pulse from the strap capture sequencer.
module rscd_mode_decode (
	input wire logic mclk,
	input wire logic rst,
	input wire logic load,
	input wire logic [4:0] code,
	output rscd_pkg::rscd_clk_mode_type mode
);

	// ----------------------------------------------------------------
	// Decode register
	// ----------------------------------------------------------------
	rscd_pkg::rscd_clk_mode_type mode_reg;
	rscd_pkg::rscd_clk_mode_type mode_next;

	always_comb begin
		mode_next = mode_reg;
		if (load) begin
			mode_next = rscd_pkg::decodeCode(code);
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			mode_reg <= '{src: rscd_pkg::CS_OFF, default: '0};
		end else begin
			mode_reg <= mode_next;
		end
	end

	assign mode = mode_reg;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	a_mult_code0: assert property (@(posedge mclk) disable iff (rst)
		(load && code == 5'h00) |=> (mode.memMultX2 == 4'h6 && mode.coreMultX2 == 4'h5))
		else $error("code 00000 did not give 3 and 2.5");
	a_mult_code2: assert property (@(posedge mclk) disable iff (rst)
		(load && code == 5'h02) |=> (mode.memMultX2 == 4'h2 && mode.coreMultX2 == 4'h9
			&& mode.corePllEn))
		else $error("code 00010 did not give 1 and 4.5");
	a_mult_code3: assert property (@(posedge mclk) disable iff (rst)
		(load && code == 5'h03) |=> (mode.memBypass && !mode.periphPllEn
			&& mode.coreMultX2 == 4'h4))
		else $error("code 00011 did not give memory bypass and 2");

endmodule : rscd_mode_decode

// ==== logic/rscd_reset_strap.sv ====
// Reset strap sampler, clock-mode capture, readback and memory lane control.
// Assumes hard resets and straps arrive synchronous to mclk; registers sit
// on a plain strobe port with read data one cycle after the read strobe.
//
// Behaviour
// - Either clock-off code stops every internal clock whatever the host reference does.
// - The captured five-bit clock code reads back in bits 7 to 3 of the register at 0xe2.
// - Single bypass clocks the core from the host reference, stops the peripheral PLL, runs 1:1.
// - Dual bypass clocks peripheral logic from the host reference at 1:1 with its PLL off.
// - Dual bypass also turns the core PLL off; the board keeps both references in step.
// - Each PLL and bypass code decodes to a host-to-memory and memory-to-core multiplier pair; both clock-off codes give zero.
// - The 32-bit bus option shuts the low lanes and upper parity receivers and drives zeros.
// - Memory data receivers stay off whenever no read is in progress.
// - All straps but the clock code are sampled while in reset and the samples set the operating options.
// - The clock code is captured a few cycles after both hard resets are negated.
// - A strap not pulled low reads as one during reset.
module rscd_reset_strap #(
	parameter int STRAP_W = 8,
	parameter int CAPTURE_DELAY = rscd_pkg::CAPTURE_DELAY_CYCLES
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic coreHardResetN,
	input wire logic ctrlHardResetN,
	input wire logic [4:0] clkCfgIn,
	output logic [4:0] clkCfgOut,
	output logic clkCfgOe,
	input wire logic [4:0] debugAddrIn,
	input wire logic [STRAP_W-1:0] strapIn,
	input wire logic busWidth32In,
	output logic strapPullupEn,
	output logic [STRAP_W-1:0] strapSampled,
	output logic busWidth32,
	output logic strapCaptured,
	output rscd_pkg::rscd_clk_mode_type clkMode,
	input wire logic memReadActive,
	input wire logic memDriveEn,
	input wire logic [31:0] lowDataOut,
	input wire logic [31:0] highDataOut,
	input wire logic [7:0] parityOut,
	output rscd_pkg::rscd_lane_ctl_type laneCtl,
	input wire logic [rscd_pkg::ADDR_W-1:0] regAddr,
	input wire logic [rscd_pkg::DATA_W-1:0] regWrData,
	input wire logic regWrStrobe,
	input wire logic regRdStrobe,
	output logic [rscd_pkg::DATA_W-1:0] regRdData
);

	// ----------------------------------------------------------------
	// Parameter checks
	// ----------------------------------------------------------------
	// Capture must land inside the window the board holds the code
	if (STRAP_W < 1 || STRAP_W > 32) begin : g_bad_strap_w
		$error("STRAP_W must be 1 to 32");
	end
	if (CAPTURE_DELAY < 1 || CAPTURE_DELAY >= rscd_pkg::HOLD_MIN_CYCLES) begin : g_bad_delay
		$error("CAPTURE_DELAY must be 1 to 24");
	end

	// ----------------------------------------------------------------
	// Capture sequencer
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_RESET = 3'b001,
		ST_WAIT = 3'b010,
		ST_HOLD = 3'b100
	} rscd_state_type;

	rscd_state_type state_reg;
	rscd_state_type state_next;
	logic [rscd_pkg::CNT_W-1:0] cnt_reg;
	logic [rscd_pkg::CNT_W-1:0] cnt_next;
	logic resetsReleased;
	logic loadCode;

	assign resetsReleased = coreHardResetN && ctrlHardResetN;

	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		loadCode = 1'b0;
		unique case (state_reg)
			ST_RESET: begin
				cnt_next = '0;
				if (resetsReleased) begin
					state_next = ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (!resetsReleased) begin
					state_next = ST_RESET;
				end else if (cnt_reg == rscd_pkg::CNT_W'(CAPTURE_DELAY - 1)) begin
					loadCode = 1'b1;
					state_next = ST_HOLD;
				end else begin
					cnt_next = cnt_reg + 1'b1;
				end
			end
			ST_HOLD: begin
				if (!resetsReleased) begin
					state_next = ST_RESET;
				end
			end
		endcase
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			state_reg <= ST_RESET;
			cnt_reg <= '0;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
		end
	end

	// ----------------------------------------------------------------
	// Strap sampling
	// ----------------------------------------------------------------
	logic [STRAP_W-1:0] strap_reg;
	logic [STRAP_W-1:0] strap_next;
	logic bus32_reg;
	logic bus32_next;
	logic [4:0] code_reg;
	logic [4:0] code_next;

	always_comb begin
		strap_next = strap_reg;
		bus32_next = bus32_reg;
		code_next = code_reg;
		if (state_reg == ST_RESET) begin
			strap_next = strapIn;
			bus32_next = busWidth32In;
		end
		if (loadCode) begin
			code_next = clkCfgIn;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			strap_reg <= '1;
			bus32_reg <= 1'b1;
			code_reg <= rscd_pkg::STRAP_RESET;
		end else begin
			strap_reg <= strap_next;
			bus32_reg <= bus32_next;
			code_reg <= code_next;
		end
	end

	assign strapPullupEn = (state_reg != ST_HOLD);
	assign strapSampled = strap_reg;
	assign busWidth32 = bus32_reg;
	assign strapCaptured = (state_reg == ST_HOLD);

	rscd_mode_decode u_decode (
		.mclk(mclk),
		.rst(rst),
		.load(loadCode),
		.code(clkCfgIn),
		.mode(clkMode)
	);

	// ----------------------------------------------------------------
	// Control register and shared pins
	// ----------------------------------------------------------------
	logic [7:0] ctrl_reg;
	logic [7:0] ctrl_next;
	logic [4:0] pinOut_reg;
	logic [4:0] pinOut_next;

	function automatic logic hitIdx(input logic [7:0] addr, input logic [7:0] idx);
		return addr == idx;
	endfunction : hitIdx

	always_comb begin
		ctrl_next = ctrl_reg;
		pinOut_next = debugAddrIn;
		if (regWrStrobe && hitIdx(regAddr, rscd_pkg::IDX_STRAP_CTRL)) begin
			ctrl_next = {7'h00, regWrData[rscd_pkg::CTRL_DBG_EN_BIT]};
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			ctrl_reg <= rscd_pkg::CTRL_RESET;
			pinOut_reg <= '0;
		end else begin
			ctrl_reg <= ctrl_next;
			pinOut_reg <= pinOut_next;
		end
	end

	// Shared strap pins only drive once the code is safely captured
	assign clkCfgOe = strapCaptured && ctrl_reg[rscd_pkg::CTRL_DBG_EN_BIT];
	assign clkCfgOut = pinOut_reg;

	// ----------------------------------------------------------------
	// Register reads
	// ----------------------------------------------------------------
	logic [7:0] rd_reg;
	logic [7:0] rd_next;
	logic [7:0] statusWord;

	always_comb begin
		statusWord = '0;
		statusWord[rscd_pkg::STAT_CAPTURED_BIT] = strapCaptured;
		statusWord[rscd_pkg::STAT_RESERVED_BIT] = (clkMode.src == rscd_pkg::CS_RESERVED);
		statusWord[rscd_pkg::STAT_BUS32_BIT] = bus32_reg;
		statusWord[rscd_pkg::STAT_OFF_BIT] = (clkMode.src == rscd_pkg::CS_OFF);
		statusWord[rscd_pkg::STAT_SBYP_BIT] = (clkMode.src == rscd_pkg::CS_SINGLE_BYP);
		statusWord[rscd_pkg::STAT_DBYP_BIT] = (clkMode.src == rscd_pkg::CS_DUAL_BYP);
	end

	always_comb begin
		rd_next = '0;
		if (regRdStrobe) begin
			if (hitIdx(regAddr, rscd_pkg::IDX_CLK_STRAP)) begin
				rd_next[7:rscd_pkg::CODE_HI_LSB] = code_reg[4:1];
				rd_next[rscd_pkg::CODE_LO_BIT] = code_reg[0];
			end else if (hitIdx(regAddr, rscd_pkg::IDX_STRAP_CTRL)) begin
				rd_next = ctrl_reg;
			end else if (hitIdx(regAddr, rscd_pkg::IDX_STRAP_STAT)) begin
				rd_next = statusWord;
			end
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			rd_reg <= '0;
		end else begin
			rd_reg <= rd_next;
		end
	end

	assign regRdData = rd_reg;

	// ----------------------------------------------------------------
	// Memory data lanes
	// ----------------------------------------------------------------
	rscd_pkg::rscd_lane_ctl_type lane_reg;
	rscd_pkg::rscd_lane_ctl_type lane_next;
	logic readOn;

	// Receivers stay dark through reset; floating lanes then draw no current
	assign readOn = memReadActive && strapCaptured;

	always_comb begin
		lane_next = '0;
		lane_next.highRxEn = readOn;
		lane_next.lowRxEn = readOn;
		lane_next.parityRxEn = {8{readOn}};
		lane_next.lowOe = memDriveEn;
		lane_next.highOe = memDriveEn;
		lane_next.lowDout = lowDataOut;
		lane_next.highDout = highDataOut;
		lane_next.parityDout = parityOut;
		if (bus32_reg) begin
			lane_next.lowRxEn = 1'b0;
			lane_next.parityRxEn[7:4] = 4'h0;
			lane_next.lowDout = '0;
			lane_next.parityDout[7:4] = 4'h0;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			lane_reg <= '0;
		end else begin
			lane_reg <= lane_next;
		end
	end

	assign laneCtl = lane_reg;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	a_clock_off_stops: assert property (@(posedge mclk) disable iff (rst)
		(loadCode && (clkCfgIn == 5'h1e || clkCfgIn == 5'h1f))
			|=> (!clkMode.clocksRun && !clkMode.corePllEn && !clkMode.periphPllEn))
		else $error("clock-off code left a clock running");
	a_readback_code: assert property (@(posedge mclk) disable iff (rst)
		(regRdStrobe && regAddr == 8'he2) |=> (regRdData[7:3] == $past(code_reg)))
		else $error("code readback at 0xe2 wrong");
	a_single_bypass: assert property (@(posedge mclk) disable iff (rst)
		(loadCode && clkCfgIn == rscd_pkg::CODE_SINGLE_BYP)
			|=> (clkMode.coreFromHostRef && !clkMode.periphPllEn
				&& clkMode.memMultX2 == 4'h2))
		else $error("single bypass settings wrong");
	a_dual_bypass: assert property (@(posedge mclk) disable iff (rst)
		(loadCode && clkCfgIn == rscd_pkg::CODE_DUAL_BYP)
			|=> (clkMode.periphFromHostRef && clkMode.coreFromCoreRef
				&& !clkMode.periphPllEn && clkMode.memMultX2 == 4'h2))
		else $error("dual bypass settings wrong");
	a_dual_core_pll: assert property (@(posedge mclk) disable iff (rst)
		(clkMode.src == rscd_pkg::CS_DUAL_BYP) |-> !clkMode.corePllEn)
		else $error("core PLL on in dual bypass");
	a_narrow_zero: assert property (@(posedge mclk) disable iff (rst)
		(bus32_reg && $past(bus32_reg)) |-> (laneCtl.lowDout == 32'h0
			&& laneCtl.parityDout[7:4] == 4'h0 && !laneCtl.lowRxEn))
		else $error("narrow bus lanes not gated");
	a_rx_idle_off: assert property (@(posedge mclk) disable iff (rst)
		!$past(memReadActive) |-> (!laneCtl.highRxEn && laneCtl.parityRxEn == 8'h00))
		else $error("receiver on with no read");
	a_low_rx_idle: assert property (@(posedge mclk) disable iff (rst)
		!$past(memReadActive) |-> !laneCtl.lowRxEn)
		else $error("low lane receiver on with no read");
	a_strap_in_reset: assert property (@(posedge mclk) disable iff (rst)
		(state_reg == ST_RESET) |=> (strapSampled == $past(strapIn)))
		else $error("strap not sampled in reset");
	a_no_early_capture: assert property (@(posedge mclk) disable iff (rst)
		$rose(resetsReleased) |-> !strapCaptured [*5])
		else $error("code captured too early");
	a_capture_on_time: assert property (@(posedge mclk) disable iff (rst)
		($rose(resetsReleased) ##1 resetsReleased [*4]) |=> strapCaptured)
		else $error("code not captured on time");
	a_pullup_reset: assert property (@(posedge mclk) disable iff (rst)
		!resetsReleased |=> (strapPullupEn && !clkCfgOe))
		else $error("strap pull-up off during reset");
	a_oe_after_capture: assert property (@(posedge mclk) disable iff (rst)
		!strapCaptured |-> !clkCfgOe)
		else $error("shared strap pins driven before capture");
	a_code_load_value: assert property (@(posedge mclk) disable iff (rst)
		loadCode |=> (code_reg == $past(clkCfgIn)))
		else $error("captured code differs from strap level");
	a_hold_captured: assert property (@(posedge mclk) disable iff (rst)
		(strapCaptured && $past(strapCaptured)) |-> ($stable(code_reg) && $stable(clkMode)))
		else $error("captured mode changed without reset");

endmodule : rscd_reset_strap

// ==== sim/rscd_board_model.sv ====
// Board side of the strap block: hard reset source and strap resistors.
// Assumes the bench sets holdReset and the pull-down masks after clock edges.
module rscd_board_model (
	input wire logic mclk,
	input wire logic holdReset,
	input wire logic [4:0] cfgPullDn,
	input wire logic [7:0] strapPullDn,
	input wire logic bus32PullDn,
	input wire logic strapPullupEn,
	input wire logic [4:0] clkCfgOut,
	input wire logic clkCfgOe,
	output logic coreHardResetN,
	output logic ctrlHardResetN,
	output logic [4:0] clkCfgIn,
	output logic [7:0] strapIn,
	output logic busWidth32In
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [4:0] cfgLast = 5'h00;
	logic [7:0] strapLast = 8'h00;
	logic bus32Last = 1'b0;

	// ----------------------------------------------------------------
	// Reset source
	// ----------------------------------------------------------------
	// Core reset trails the controller reset, so both must be seen high
	always @(posedge mclk) begin
		ctrlHardResetN <= !holdReset;
		coreHardResetN <= !holdReset && ctrlHardResetN;
		cfgLast <= clkCfgIn;
		strapLast <= strapIn;
		bus32Last <= busWidth32In;
	end

	// ----------------------------------------------------------------
	// Strap pins
	// ----------------------------------------------------------------
	// pull-downs only, static
	// Open pins without the internal pull-up show a changing level
	assign clkCfgIn = clkCfgOe ? clkCfgOut
		: (~cfgPullDn & (strapPullupEn ? 5'h1f : ~cfgLast));
	assign strapIn = ~strapPullDn & (strapPullupEn ? 8'hff : ~strapLast);
	assign busWidth32In = !bus32PullDn && (strapPullupEn || !bus32Last);
endmodule : rscd_board_model

// ==== sim/tb_rscd_reset_strap.sv ====
// Self-checking bench for the reset strap block.
// Assumes the board model and a 20 MHz clock; no other parties.
module tb_rscd_reset_strap;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int CD = 4;
	logic mclk, rst, holdReset, bus32PullDn, coreHardResetN, ctrlHardResetN;
	logic [4:0] cfgPullDn, clkCfgIn, clkCfgOut, debugAddrIn;
	logic [7:0] strapPullDn, strapIn, strapSampled, regAddr, regWrData, regRdData, parityOut, d;
	logic clkCfgOe, busWidth32In, strapPullupEn, busWidth32, strapCaptured;
	logic memReadActive, memDriveEn, regWrStrobe, regRdStrobe;
	logic [31:0] lowDataOut, highDataOut;
	rscd_pkg::rscd_clk_mode_type clkMode;
	rscd_pkg::rscd_lane_ctl_type laneCtl, el;
	logic [4:0] codes [9] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h1c, 5'h1d, 5'h1e, 5'h1f};
	int failures = 0;
	int comparisons = 0;

	rscd_reset_strap #(.STRAP_W(8), .CAPTURE_DELAY(CD)) dut_u (.mclk(mclk), .rst(rst),
		.coreHardResetN(coreHardResetN), .ctrlHardResetN(ctrlHardResetN),
		.clkCfgIn(clkCfgIn), .clkCfgOut(clkCfgOut), .clkCfgOe(clkCfgOe),
		.debugAddrIn(debugAddrIn), .strapIn(strapIn), .busWidth32In(busWidth32In),
		.strapPullupEn(strapPullupEn), .strapSampled(strapSampled), .busWidth32(busWidth32),
		.strapCaptured(strapCaptured), .clkMode(clkMode), .memReadActive(memReadActive),
		.memDriveEn(memDriveEn), .lowDataOut(lowDataOut), .highDataOut(highDataOut),
		.parityOut(parityOut), .laneCtl(laneCtl), .regAddr(regAddr), .regWrData(regWrData),
		.regWrStrobe(regWrStrobe), .regRdStrobe(regRdStrobe), .regRdData(regRdData));
	rscd_board_model board_u (.mclk(mclk), .holdReset(holdReset), .cfgPullDn(cfgPullDn),
		.strapPullDn(strapPullDn), .bus32PullDn(bus32PullDn), .strapPullupEn(strapPullupEn),
		.clkCfgOut(clkCfgOut), .clkCfgOe(clkCfgOe), .coreHardResetN(coreHardResetN),
		.ctrlHardResetN(ctrlHardResetN), .clkCfgIn(clkCfgIn), .strapIn(strapIn),
		.busWidth32In(busWidth32In));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic report_and_stop();
		$display("Comparisons %0d, mismatches %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : report_and_stop

	task automatic chk(input string what, input logic [95:0] exp, input logic [95:0] got);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic regWrite(input logic [7:0] a, input logic [7:0] v);
		@(posedge mclk);
		regAddr <= a;
		regWrData <= v;
		regWrStrobe <= 1'b1;
		@(posedge mclk);
		regWrStrobe <= 1'b0;
	endtask : regWrite

	task automatic regRead(input logic [7:0] a, output logic [7:0] v);
		@(posedge mclk);
		regAddr <= a;
		regRdStrobe <= 1'b1;
		@(posedge mclk);
		regRdStrobe <= 1'b0;
		#1;
		v = regRdData;
	endtask : regRead

	// Multipliers held as twice their value
	function automatic rscd_pkg::rscd_clk_mode_type expMode(input logic [4:0] c);
		rscd_pkg::rscd_clk_mode_type m;
		m = '0;
		m.src = rscd_pkg::CS_PLL;
		m.periphPllEn = 1'b1;
		m.corePllEn = 1'b1;
		m.clocksRun = 1'b1;
		case (c)
			5'h00: {m.memMultX2, m.coreMultX2} = 8'h65;
			5'h01: {m.memMultX2, m.coreMultX2} = 8'h66;
			5'h02: {m.memMultX2, m.coreMultX2} = 8'h29;
			5'h03: {m.memMultX2, m.coreMultX2, m.memBypass, m.periphPllEn} = 10'b0010_0100_10;
			5'h04: {m.memMultX2, m.coreMultX2} = 8'h44;
			5'h1c: begin
				m.src = rscd_pkg::CS_SINGLE_BYP;
				{m.memMultX2, m.coreMultX2, m.periphPllEn, m.corePllEn} = 10'h088;
				m.coreFromHostRef = 1'b1;
			end
			5'h1d: begin
				m.src = rscd_pkg::CS_DUAL_BYP;
				{m.memMultX2, m.coreMultX2, m.periphPllEn, m.corePllEn} = 10'h088;
				{m.coreFromCoreRef, m.periphFromHostRef} = 2'b11;
			end
			default: begin
				m = '0;
				m.src = rscd_pkg::CS_OFF;
			end
		endcase
		return m;
	endfunction : expMode

	task automatic waitRelease();
		for (int n = 0; n <= 50; n++) begin
			@(posedge mclk);
			if (coreHardResetN === 1'b1 && ctrlHardResetN === 1'b1) break;
			if (n == 50) failures++;
		end
	endtask : waitRelease

	// Hard reset cycle with the given straps; abort drops reset mid-wait
	task automatic capture(input logic [4:0] code, input logic bus32, input logic abort);
		@(posedge mclk);
		holdReset <= 1'b1;
		cfgPullDn <= ~code;
		strapPullDn <= {3'h0, ~code};
		bus32PullDn <= !bus32;
		repeat (3) @(posedge mclk);
		holdReset <= 1'b0;
		waitRelease();
		if (abort) begin
			holdReset <= 1'b1;
			repeat (3) @(posedge mclk);
			holdReset <= 1'b0;
			waitRelease();
		end
		repeat (CD - 1) @(posedge mclk);
		#1;
		chk("captured early", 96'h0, 96'(strapCaptured));
		chk("pullup on", 96'h1, 96'(strapPullupEn));
		@(posedge mclk);
		#1;
		chk("captured", 96'h1, 96'(strapCaptured));
		chk("pullup off", 96'h0, 96'(strapPullupEn));
		chk("clock mode", 96'(expMode(code)), 96'(clkMode));
		chk("straps", 96'({3'h7, code}), 96'(strapSampled));
		chk("bus option", 96'(bus32), 96'(busWidth32));
		// Board keeps the straps through the hold window before any change
		repeat (rscd_pkg::HOLD_MIN_CYCLES) @(posedge mclk);
	endtask : capture

	task automatic laneTest(input logic b);
		@(posedge mclk);
		memReadActive <= 1'b0;
		memDriveEn <= 1'b1;
		lowDataOut <= 32'ha5a5_0f0f;
		highDataOut <= 32'h1234_5678;
		parityOut <= 8'hc3;
		@(posedge mclk);
		memReadActive <= 1'b1;
		memDriveEn <= 1'b0;
		#1;
		el = '0;
		el.lowDout = b ? 32'h0 : 32'ha5a5_0f0f;
		el.highDout = 32'h1234_5678;
		el.parityDout = b ? 8'h03 : 8'hc3;
		{el.lowOe, el.highOe} = 2'b11;
		chk("lanes driving", 96'(el), 96'(laneCtl));
		@(posedge mclk);
		memReadActive <= 1'b0;
		#1;
		chk("lanes reading", 96'({!b, 1'b1, {4{!b}}, 4'hf}),
			96'({laneCtl.lowRxEn, laneCtl.highRxEn, laneCtl.parityRxEn}));
	endtask : laneTest

	// ----------------------------------------------------------------
	// Sequence
	// ----------------------------------------------------------------
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end

	initial begin
		repeat (5000) @(posedge mclk);
		failures++;
		report_and_stop();
	end

	initial begin
		{rst, holdReset, bus32PullDn, cfgPullDn, strapPullDn} = {2'b11, 14'h0};
		{regAddr, regWrData, regWrStrobe, regRdStrobe} = 18'h0;
		{memReadActive, memDriveEn, lowDataOut, highDataOut, parityOut} = 74'h0;
		debugAddrIn = 5'h0a;
		repeat (12) @(posedge mclk);
		rst <= 1'b0;
		foreach (codes[i]) begin
			capture(codes[i], 1'(i % 2), i == 2);
			regWrite(8'he2, 8'hff);
			regRead(8'he2, d);
			chk("readback", 96'({codes[i], 3'h0}), 96'(d));
			regRead(8'he4, d);
			chk("status", 96'({2'b00, codes[i] == 5'h1d, codes[i] == 5'h1c,
				codes[i][4:1] == 4'hf, 1'(i % 2), 2'b01}), 96'(d));
		end
		for (int b = 0; b < 2; b++) begin
			capture(5'h00, 1'(b), 1'b0);
			laneTest(1'(b));
		end
		regRead(8'h10, d);
		chk("unmapped", 96'h0, 96'(d));
		regWrite(8'he3, 8'h01);
		regRead(8'he3, d);
		chk("control", 96'h1, 96'(d));
		// Pins now driven by the block and the board straps flip
		cfgPullDn <= 5'h00;
		strapPullDn <= 8'hff;
		bus32PullDn <= 1'b1;
		repeat (30) @(posedge mclk);
		#1;
		chk("pin drive", 96'({1'b1, 5'h0a}), 96'({clkCfgOe, clkCfgOut}));
		chk("mode held", 96'(expMode(5'h00)), 96'(clkMode));
		chk("straps held", 96'({3'h7, 5'h00, 1'b1}), 96'({strapSampled, busWidth32}));
		regRead(8'he2, d);
		chk("readback held", 96'h0, 96'(d));
		regWrite(8'he3, 8'h00);
		report_and_stop();
	end
endmodule : tb_rscd_reset_strap
